// File: design/hlc_pkg.sv
package hlc_pkg;

  // Register byte offsets on the APB window
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFF_ROM_BASE    = 8'h00;
  localparam logic [7:0]  OFF_LOG_UPPER   = 8'h04;
  localparam logic [7:0]  OFF_LOG_LOWER   = 8'h08;
  localparam logic [7:0]  OFF_MAKER_ID    = 8'h0C;
  localparam logic [7:0]  OFF_HC_SET      = 8'h10;
  localparam logic [7:0]  OFF_HC_CLEAR    = 8'h14;
  localparam logic [7:0]  OFF_EVENT       = 8'h18;
  localparam logic [7:0]  OFF_EVENT_CLEAR = 8'h1C;

  // Configuration ROM mapping
  localparam int          ROM_BASE_LSB    = 10;
  localparam int          ROM_BASE_W      = 22;
  localparam int          ROM_OFF_W       = 10;
  localparam logic [9:0]  ROM_LOCAL_BYTES = 10'h014;
  localparam logic [21:0] ROM_BASE_RST    = 22'h000000;

  // Deferred write log layout
  localparam int          LOG_DEPTH       = 4;
  localparam int          NODE_W          = 16;
  localparam int          OFFSET_W        = 48;
  localparam int          ENTRY_W         = 64;

  // Maker identifier fields (values arbitrary)
  localparam logic [7:0]  MAKER_UNIQUE    = 8'h5A;
  localparam logic [23:0] MAKER_COMPANY   = 24'hC3E1A5;
  localparam int          MAKER_UNIQUE_LSB = 24;

  // Host control and event bit positions
  localparam int          HC_BIO_BIT      = 31;
  localparam int          HC_ENDIAN_BIT   = 30;
  localparam int          HC_LATE_ACK_BIT = 29;
  localparam int          HC_PHY_PROG_BIT = 23;
  localparam int          HC_PHY_ENH_BIT  = 22;
  localparam int          HC_LPS_BIT      = 19;
  localparam int          HC_DWO_BIT      = 18;
  localparam int          HC_LINK_ON_BIT  = 17;
  localparam int          HC_SRST_BIT     = 16;
  localparam int          EVT_FAULT_BIT   = 0;

  // Host control reset values and fixed read values
  localparam logic        BIO_RST         = 1'b0;
  localparam logic        ENDIAN_RST      = 1'b0;
  localparam logic        LPS_RST         = 1'b0;
  localparam logic        DWO_RST         = 1'b0;
  localparam logic        LINK_ON_RST     = 1'b0;
  localparam logic        PHY_PROG_VAL    = 1'b0;
  localparam logic        PHY_ENH_VAL     = 1'b1;

  // Reset sequencing time
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          SRST_TIME_NS    = 640;
  localparam int          SRST_CYCLES     = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SRST_CNT_W      = 8;

  typedef enum logic [2:0] {
    ST_HWRST = 3'b001,
    ST_IDLE  = 3'b010,
    ST_SWRST = 3'b100
  } hlc_state_t;

endpackage

// File: design/hlc_regs.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - ROM base writable in bits 31:10
// - First 20 ROM bytes ignore the base
// - Bus error logs sender and offset
// - Log captures only with deferred write on
// - Log is a four-entry FIFO
// - Stored entry raises the fault flag
// - Upper word: sender and high offset
// - Lower word: low 32 offset bits
// - Maker identifier is a fixed constant
// - Bit 30 selects big endian
// - Bit 23 reads zero, bit 22 one
// - Disconnect clears link on by itself
// - Bit 29 reserved, reads zero
// - Image invalid gives type error answers
// - Bit 19 switches link power on
// - Bit 18 enables deferred writes
// - Bit 17 enables the link
// - Bit 16 starts reset, reads busy
module hlc_regs #(
  parameter int          LOG_DEPTH     = hlc_pkg::LOG_DEPTH,
  parameter int          SRST_CYCLES   = hlc_pkg::SRST_CYCLES,
  parameter logic [7:0]  MAKER_UNIQUE  = hlc_pkg::MAKER_UNIQUE,
  parameter logic [23:0] MAKER_COMPANY = hlc_pkg::MAKER_COMPANY
) (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [hlc_pkg::ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                     pwdata,
  output logic [31:0]                          prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            disconnect_pin,
  input  wire logic                            log_capture,
  input  wire logic [hlc_pkg::NODE_W-1:0]      log_node,
  input  wire logic [hlc_pkg::OFFSET_W-1:0]    log_offset,
  input  wire logic                            rom_req,
  input  wire logic [hlc_pkg::ROM_OFF_W-1:0]   rom_off,
  output logic                                 rom_valid,
  output logic                                 rom_local_sel,
  output logic [31:0]                          rom_host_addr,
  output logic                                 endian_big,
  output logic                                 link_power_on,
  output logic                                 link_on,
  output logic                                 deferred_write_on,
  output logic                                 bus_info_image_ok,
  output logic                                 block_read_type_error,
  output logic                                 soft_reset_active,
  output logic                                 deferred_write_fault,
  output logic [hlc_pkg::ROM_BASE_W-1:0]       rom_base_field
);
  import hlc_pkg::*;

  localparam int PW = (LOG_DEPTH > 1) ? $clog2(LOG_DEPTH) : 1;

  // Pointers wrap by overflow, so the depth must be a power of two
  if (LOG_DEPTH < 2 || (LOG_DEPTH & (LOG_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hlc_regs: LOG_DEPTH must be a power of two, at least 2");
  end
  if (SRST_CYCLES < 1 || SRST_CYCLES > 255) begin : g_bad_srst
    $error("hlc_regs: SRST_CYCLES must be 1 to 255");
  end

  typedef struct packed {
    hlc_state_t                         st;
    logic [SRST_CNT_W-1:0]              rst_cnt;
    logic [SRST_CNT_W-1:0]              busy_len;
    logic [ROM_BASE_W-1:0]              rom_base;
    logic                               bio;
    logic                               endian;
    logic                               link_power_status;
    logic                               dwo;
    logic                               link_on;
    logic                               fault;
    logic [LOG_DEPTH-1:0][ENTRY_W-1:0]  mem;
    logic [PW-1:0]                      wr_ptr;
    logic [PW-1:0]                      rd_ptr;
    logic [PW:0]                        count;
    logic [31:0]                        prdata;
    logic                               pslverr;
    logic                               disc_meta;
    logic                               disc_sync;
    logic                               rom_valid;
    logic                               rom_local;
    logic [31:0]                        rom_addr;
  } hlc_regs_state_t;

  hlc_regs_state_t r_reg;
  hlc_regs_state_t r_next;

  logic        setup;
  logic        wr;
  logic        rd;
  logic        busy;
  logic        push;
  logic        pop;
  logic        clr_fault;
  logic [31:0] hc_word;
  logic [ENTRY_W-1:0] head;

  // APB phases; the slave never inserts wait states
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign busy   = (r_reg.st != ST_IDLE);
  assign head   = r_reg.mem[r_reg.rd_ptr];

  // Host control read image, fixed bits forced
  always_comb begin
    hc_word                  = 32'h00000000;
    hc_word[HC_BIO_BIT]      = r_reg.bio;
    hc_word[HC_ENDIAN_BIT]   = r_reg.endian;
    hc_word[HC_LATE_ACK_BIT] = 1'b0;
    hc_word[HC_PHY_PROG_BIT] = PHY_PROG_VAL;
    hc_word[HC_PHY_ENH_BIT]  = PHY_ENH_VAL;
    hc_word[HC_LPS_BIT]      = r_reg.link_power_status;
    hc_word[HC_DWO_BIT]      = r_reg.dwo;
    hc_word[HC_LINK_ON_BIT]  = r_reg.link_on;
    hc_word[HC_SRST_BIT]     = busy;
  end

  // Log queue handshakes; captures during reset are dropped
  assign push      = log_capture & r_reg.dwo & ~busy
                     & (r_reg.count < (PW+1)'(LOG_DEPTH));
  assign pop       = rd & (paddr == OFF_LOG_LOWER)
                     & (r_reg.count != '0);
  assign clr_fault = wr & (paddr == OFF_EVENT_CLEAR) & pwdata[EVT_FAULT_BIT];

  // Next-state logic for the whole register bank
  always_comb begin
    r_next = r_reg;

    // Disconnect pin crosses in from the link side
    r_next.disc_meta = disconnect_pin;
    r_next.disc_sync = r_reg.disc_meta;

    // Read data latched in setup so prdata comes from a flop
    if (setup) begin
      r_next.pslverr = 1'b0;
      case (paddr)
        OFF_ROM_BASE:    r_next.prdata = {r_reg.rom_base, 10'h000};
        OFF_LOG_UPPER:   r_next.prdata = head[ENTRY_W-1:32];
        OFF_LOG_LOWER:   r_next.prdata = head[31:0];
        OFF_MAKER_ID:    r_next.prdata = {MAKER_UNIQUE, MAKER_COMPANY};
        OFF_HC_SET:      r_next.prdata = hc_word;
        OFF_HC_CLEAR:    r_next.prdata = hc_word;
        OFF_EVENT:       r_next.prdata = {31'h00000000, r_reg.fault};
        OFF_EVENT_CLEAR: r_next.prdata = {31'h00000000, r_reg.fault};
        default: begin
          r_next.prdata  = 32'h00000000;
          r_next.pslverr = 1'b1;
        end
      endcase
    end

    // ROM base takes the top 22 bits, low bits dropped
    if (wr && paddr == OFF_ROM_BASE) begin
      r_next.rom_base = pwdata[31:ROM_BASE_LSB];
    end

    // Control bits: ones set or clear, zeros leave alone
    if (wr && paddr == OFF_HC_SET) begin
      r_next.bio     = r_reg.bio     | pwdata[HC_BIO_BIT];
      r_next.endian  = r_reg.endian  | pwdata[HC_ENDIAN_BIT];
      r_next.link_power_status     = r_reg.link_power_status     | pwdata[HC_LPS_BIT];
      r_next.dwo     = r_reg.dwo     | pwdata[HC_DWO_BIT];
      r_next.link_on = r_reg.link_on | pwdata[HC_LINK_ON_BIT];
    end
    if (wr && paddr == OFF_HC_CLEAR) begin
      r_next.bio     = r_reg.bio     & ~pwdata[HC_BIO_BIT];
      r_next.endian  = r_reg.endian  & ~pwdata[HC_ENDIAN_BIT];
      r_next.link_power_status     = r_reg.link_power_status     & ~pwdata[HC_LPS_BIT];
      r_next.dwo     = r_reg.dwo     & ~pwdata[HC_DWO_BIT];
      r_next.link_on = r_reg.link_on & ~pwdata[HC_LINK_ON_BIT];
    end

    // Queue storage and occupancy
    if (push) begin
      r_next.mem[r_reg.wr_ptr] = {log_node, log_offset};
      r_next.wr_ptr            = r_reg.wr_ptr + PW'(1);
    end
    if (pop) begin
      r_next.rd_ptr = r_reg.rd_ptr + PW'(1);
    end
    r_next.count = r_reg.count + (PW+1)'(push) - (PW+1)'(pop);

    // Fault flag: a new entry beats a clear, leftovers re-raise it
    r_next.fault = (r_reg.fault & ~clr_fault) | push
                   | (clr_fault & (r_next.count != '0));

    // Disconnect wins over a software set of link on
    if (r_reg.disc_sync) begin
      r_next.link_on = 1'b0;
    end

    // Reset sequencer; hardware release also runs the busy window
    case (r_reg.st)
      ST_IDLE: begin
        if (wr && paddr == OFF_HC_SET && pwdata[HC_SRST_BIT]) begin
          r_next.st      = ST_SWRST;
          r_next.rst_cnt = '0;
        end
      end
      ST_HWRST, ST_SWRST: begin
        r_next.link_on = 1'b0;
        r_next.bio     = 1'b0;
        r_next.wr_ptr  = '0;
        r_next.rd_ptr  = '0;
        r_next.count   = '0;
        r_next.fault   = 1'b0;
        if (r_reg.rst_cnt == SRST_CNT_W'(SRST_CYCLES - 1)) begin
          r_next.st = ST_IDLE;
        end else begin
          r_next.rst_cnt = r_reg.rst_cnt + SRST_CNT_W'(1);
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    // Busy run length, counted apart from the sequencer for the checks
    r_next.busy_len = busy ? r_reg.busy_len + SRST_CNT_W'(1) : '0;

    // ROM lookup: the leading bytes never use the base
    r_next.rom_valid = rom_req;
    if (rom_req) begin
      r_next.rom_local = (rom_off < ROM_LOCAL_BYTES);
      r_next.rom_addr  = {r_reg.rom_base, rom_off};
    end
  end

  // Single state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg          <= '0;
      r_reg.st       <= ST_HWRST;
      r_reg.rom_base <= ROM_BASE_RST;
      r_reg.bio      <= BIO_RST;
      r_reg.endian   <= ENDIAN_RST;
      r_reg.link_power_status      <= LPS_RST;
      r_reg.dwo      <= DWO_RST;
      r_reg.link_on  <= LINK_ON_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign prdata                = r_reg.prdata;
  assign pslverr               = r_reg.pslverr;
  assign rom_valid             = r_reg.rom_valid;
  assign rom_local_sel         = r_reg.rom_local;
  assign rom_host_addr         = r_reg.rom_addr;
  assign endian_big            = r_reg.endian;
  assign link_power_on         = r_reg.link_power_status;
  assign link_on               = r_reg.link_on;
  assign deferred_write_on     = r_reg.dwo;
  assign bus_info_image_ok     = r_reg.bio;
  assign block_read_type_error = ~r_reg.bio;
  assign soft_reset_active     = busy;
  assign deferred_write_fault  = r_reg.fault;
  assign rom_base_field        = r_reg.rom_base;

  // Checks, all in the pclk domain
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_srst_start;
    wr && paddr == OFF_HC_SET && pwdata[HC_SRST_BIT] && !busy;
  endsequence
  sequence s_srst_busy;
    soft_reset_active;
  endsequence
  // Two separate transfers, so the lower read is at least two cycles on
  sequence s_log_read_pair;
    (rd && paddr == OFF_LOG_UPPER) ##[2:8] (rd && paddr == OFF_LOG_LOWER);
  endsequence

  AST_ROM_BASE_WRITE: assert property (
    wr && paddr == OFF_ROM_BASE |=> rom_base_field == $past(pwdata[31:10]))
    else $error("rom base not taken from write data");

  AST_ROM_LOCAL: assert property (
    rom_req && rom_off < ROM_LOCAL_BYTES |=> rom_valid && rom_local_sel)
    else $error("leading rom bytes not served locally");

  AST_LOG_GATED: assert property (
    log_capture && !deferred_write_on && !pop && !busy |=> $stable(r_reg.count))
    else $error("log captured while deferred write off");

  AST_LOG_DEPTH: assert property (
    r_reg.count <= (PW+1)'(LOG_DEPTH))
    else $error("log count above depth");

  AST_FAULT_RAISE: assert property (
    push |=> deferred_write_fault && r_reg.count != '0)
    else $error("stored entry did not raise fault");

  AST_LOG_POP_PAIR: assert property (
    s_log_read_pair ##0 (r_reg.count != '0 && !push && !busy)
    |=> r_reg.count == $past(r_reg.count) - (PW+1)'(1))
    else $error("lower read did not retire one entry");

  AST_FIXED_BITS: assert property (
    rd && (paddr == OFF_HC_SET || paddr == OFF_HC_CLEAR)
    |-> prdata[HC_PHY_ENH_BIT] && !prdata[HC_PHY_PROG_BIT] && !prdata[HC_LATE_ACK_BIT])
    else $error("fixed control bits read wrong");

  AST_DISCONNECT: assert property (
    r_reg.disc_sync |=> !link_on)
    else $error("disconnect left link on");

  AST_TYPE_ERROR: assert property (
    block_read_type_error != bus_info_image_ok)
    else $error("type error answer not tied to image valid");

  AST_LPS_SET: assert property (
    wr && paddr == OFF_HC_SET && pwdata[HC_LPS_BIT] |=> link_power_on)
    else $error("link power did not switch on");

  AST_SRST_WINDOW: assert property (
    s_srst_start |=> s_srst_busy ##[1:260] !soft_reset_active)
    else $error("software reset window wrong");

  AST_CLEAR_ONES: assert property (
    wr && paddr == OFF_HC_CLEAR && pwdata[HC_DWO_BIT] |=> !deferred_write_on)
    else $error("clear address did not clear bit");

  // Busy window length checked against an independent run counter
  AST_SRST_LEN: assert property (
    $fell(soft_reset_active) |-> r_reg.busy_len == SRST_CNT_W'(SRST_CYCLES))
    else $error("reset busy window length wrong");

  // Read data was latched one edge earlier, in the setup cycle
  AST_SRST_READ: assert property (
    rd && paddr == OFF_HC_SET |-> prdata[HC_SRST_BIT] == $past(soft_reset_active))
    else $error("reset progress bit read wrong");

  AST_BIO_SET: assert property (
    wr && paddr == OFF_HC_SET && pwdata[HC_BIO_BIT] && !busy
    |=> bus_info_image_ok && !block_read_type_error)
    else $error("image valid set did not stop type errors");

  AST_ENDIAN_SET: assert property (
    wr && paddr == OFF_HC_SET && pwdata[HC_ENDIAN_BIT] |=> endian_big)
    else $error("endian select did not set");

  AST_DWO_SET: assert property (
    wr && paddr == OFF_HC_SET && pwdata[HC_DWO_BIT] |=> deferred_write_on)
    else $error("deferred write enable did not set");

  // A disconnect in flight may legally beat the set
  AST_LINK_ON_SET: assert property (
    wr && paddr == OFF_HC_SET && pwdata[HC_LINK_ON_BIT] && !busy && !r_reg.disc_sync
    |=> link_on)
    else $error("link enable did not set");

  // A full queue drops the newcomer rather than overwrite the oldest
  AST_LOG_FULL: assert property (
    log_capture && r_reg.count == (PW+1)'(LOG_DEPTH) && !pop && !busy
    |=> $stable(r_reg.count))
    else $error("full log took another entry");

endmodule

`default_nettype wire

// File: dv/hlc_link_model.sv
`timescale 1ns/100ps
`default_nettype none

module hlc_link_model (
  input  wire logic                         pclk,
  output logic                              log_capture,
  output logic [hlc_pkg::NODE_W-1:0]        log_node,
  output logic [hlc_pkg::OFFSET_W-1:0]      log_offset,
  output logic                              rom_req,
  output logic [hlc_pkg::ROM_OFF_W-1:0]     rom_off,
  output logic                              disconnect_pin
);
  import hlc_pkg::*;

  // Quiet link at start
  initial begin
    log_capture    = 1'b0;
    log_node       = '0;
    log_offset     = '0;
    rom_req        = 1'b0;
    rom_off        = '0;
    disconnect_pin = 1'b0;
  end

  // One failed payload store, one per call
  task automatic capture(input logic [NODE_W-1:0] n, input logic [OFFSET_W-1:0] o);
    @(posedge pclk);
    log_capture <= 1'b1;
    log_node    <= n;
    log_offset  <= o;
  endtask

  // ROM lookup request
  task automatic lookup(input logic [ROM_OFF_W-1:0] off);
    @(posedge pclk);
    rom_req <= 1'b1;
    rom_off <= off;
  endtask

  // Released lines flip so stale data never looks valid
  task automatic idle();
    @(posedge pclk);
    log_capture <= 1'b0;
    rom_req     <= 1'b0;
    log_node    <= ~log_node;
    log_offset  <= ~log_offset;
    rom_off     <= ~rom_off;
  endtask

  // Network cable state
  task automatic cut(input logic v);
    @(posedge pclk);
    disconnect_pin <= v;
  endtask
endmodule

`default_nettype wire

// File: dv/host_link_control_registers_test.sv
`timescale 1ns/100ps
`default_nettype none

module host_link_control_registers_test;
  import hlc_pkg::*;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rom_host_addr;
  logic er, disconnect_pin, log_capture, rom_req, rom_valid, rom_local_sel;
  logic endian_big, link_power_on, link_on, deferred_write_on, bus_info_image_ok;
  logic block_read_type_error, soft_reset_active, deferred_write_fault;
  logic [15:0] log_node;
  logic [47:0] log_offset;
  logic [9:0] rom_off;
  logic [21:0] rom_base_field;
  int error_cnt = 0;
  int n_tests = 0;
  typedef struct { logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e; } hlc_row_t;
  hlc_row_t rows [9] = '{
    '{0, 8'h0C, 32'h0, 32'h5AC3E1A5, 0}, '{1, 8'h0C, 32'hFFFFFFFF, 32'h0, 0},
    '{0, 8'h0C, 32'h0, 32'h5AC3E1A5, 0}, '{0, 8'h10, 32'h0, 32'h00400000, 0},
    '{1, 8'h10, 32'h20C00000, 32'h0, 0}, '{0, 8'h10, 32'h0, 32'h00400000, 0},
    '{1, 8'h00, 32'hFFFFFFFF, 32'h0, 0}, '{0, 8'h00, 32'h0, 32'hFFFFFC00, 0},
    '{0, 8'h20, 32'h0, 32'h0, 1}};

  hlc_regs #(.SRST_CYCLES(2)) u_hlc_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .disconnect_pin(disconnect_pin),
    .log_capture(log_capture), .log_node(log_node), .log_offset(log_offset), .rom_req(rom_req),
    .rom_off(rom_off), .rom_valid(rom_valid), .rom_local_sel(rom_local_sel),
    .rom_host_addr(rom_host_addr), .endian_big(endian_big), .link_power_on(link_power_on),
    .link_on(link_on), .deferred_write_on(deferred_write_on),
    .bus_info_image_ok(bus_info_image_ok), .block_read_type_error(block_read_type_error),
    .soft_reset_active(soft_reset_active), .deferred_write_fault(deferred_write_fault),
    .rom_base_field(rom_base_field));
  hlc_link_model u_hlc_link_model (.pclk(pclk), .log_capture(log_capture), .log_node(log_node),
    .log_offset(log_offset), .rom_req(rom_req), .rom_off(rom_off),
    .disconnect_pin(disconnect_pin));

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(string s, logic [63:0] seen, logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // APB transfer; read data and error taken at the pready edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait for the reset busy window to close
  task automatic wait_idle();
    for (int k = 0; k < 50 && soft_reset_active !== 1'b0; k++) @(posedge pclk);
    #1 chk("soft_reset_active", soft_reset_active, 0);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog sized well past the expected run
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", er, rows[i].e);
      if (!rows[i].w) chk("prdata", rd, rows[i].x);
    end
    chk("rom_base_field", rom_base_field, 22'h3FFFFF);
    $display("table done");
    // Endian, power, deferred set before link on; zero bits act on nothing
    apb(1, 8'h10, 32'h400C0000);
    apb(1, 8'h10, 32'h00020000);
    apb(1, 8'h14, 32'h0);
    apb(0, 8'h10, 32'h0);
    chk("control", rd, 32'h404E0000);
    chk("outs", {endian_big, link_power_on, deferred_write_on, link_on}, 4'hF);
    apb(1, 8'h14, 32'h00080000);
    apb(0, 8'h14, 32'h0);
    chk("control clr", rd, 32'h40460000);
    chk("link_power_on", link_power_on, 0);
    apb(1, 8'h10, 32'h80000000);
    #1 chk("image ok", {bus_info_image_ok, block_read_type_error}, 2'b10);
    apb(1, 8'h14, 32'h80000000);
    #1 chk("type error", {bus_info_image_ok, block_read_type_error}, 2'b01);
    $display("control done");
    // ROM lookups either side of the local 20 bytes
    u_hlc_link_model.lookup(10'd19);
    u_hlc_link_model.idle();
    #1 chk("rom local", {rom_valid, rom_local_sel}, 2'b11);
    u_hlc_link_model.lookup(10'd20);
    u_hlc_link_model.idle();
    #1 chk("rom host", {rom_valid, rom_local_sel, rom_host_addr}, {2'b10, 32'hFFFFFC14});
    $display("rom done");
    // Five back to back faults into a four deep log
    for (int i = 0; i < 5; i++) begin
      u_hlc_link_model.capture(16'h1000 + i[15:0], {16'hBEE0 + i[15:0], 32'h12345670 + i[31:0]});
    end
    u_hlc_link_model.idle();
    #1 chk("fault", deferred_write_fault, 1);
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'h04, 32'h0);
      chk("log upper", rd, {16'h1000 + i[15:0], 16'hBEE0 + i[15:0]});
      apb(0, 8'h08, 32'h0);
      chk("log lower", rd, 32'h12345670 + i);
      apb(1, 8'h1C, 32'h1);
      apb(0, 8'h18, 32'h0);
      chk("fault left", rd, {31'h0, i < 3});
    end
    apb(1, 8'h14, 32'h00020000);
    apb(1, 8'h14, 32'h00040000);
    u_hlc_link_model.capture(16'h0001, 48'h1);
    u_hlc_link_model.idle();
    repeat (2) @(posedge pclk);
    #1 chk("fault off", deferred_write_fault, 0);
    $display("log done");
    // Disconnect drops the link by itself
    apb(1, 8'h10, 32'h00020000);
    u_hlc_link_model.cut(1);
    repeat (4) @(posedge pclk);
    #1 chk("link_on disc", link_on, 0);
    u_hlc_link_model.cut(0);
    $display("disconnect done");
    // Software reset, then a hardware reset after its busy window closes
    apb(1, 8'h10, 32'h00030000);
    @(posedge pclk);
    #1 chk("srst busy", soft_reset_active, 1);
    wait_idle();
    chk("link after srst", link_on, 0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1 chk("hw reset", {soft_reset_active, link_on, block_read_type_error}, 3'b101);
    @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    $display("reset done");
    conclude();
  end
endmodule

`default_nettype wire
